// [hw/rtcca_top.sv]
// clock calendar unit: bcd time and date, calibration, masked alarm, output pin
//
// Contract
// - seconds advance once per 32768 crystal edges before calibration.
// - 24-hour time; hours wrap 23 to 00 and advance the date.
// - half-second flag reads 1 in second half of each second.
// - calendar 2000-2099 with leap years giving February 29 days.
// - all time, date and alarm values held as bcd tens and units.
// - alarm interval from half second up to once a year.
// - alarm repeat counter decrements by one on each alarm event, except an event at zero with chime off.
// - chime repeats the alarm indefinitely.
// - signed 10-bit calibration adds or removes crystal pulses once a minute.
// - clear, set, invert aliases at register address plus 0x4, 0x8, 0xC.
// - module enable bit writable only while value write enable is 1.
// - value write enable can be set only during the unlock sequence.
// - stop-in-idle cuts the bus interface while the device idles.
// - output select routes seconds clock (1) or alarm pulse (0) to pin.
// - pin output active only while output enable bit is 1.
// - clock running status reads 1 while the clock runs.
// - half-second flag read-only, cleared by a write of the seconds fields.
// - control, alarm control, time, alarm time and alarm date reset to zero; date resets to 2000-01-01.
// - 4-bit alarm mask codes 0000..1001 select the interval, rest reserved.
// - repeat counter wraps 0x00 to 0xFF only with chime, else stops.
// - alarm enable clears on event with counter zero and chime off.
// - time and date writes blocked while value write enable is 0.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "rtcca_regs.svh"

module rtcca_top
    import rtcca_pkg::*;
#(
    parameter int XTAL_CYCLES = `RTCCA_XTAL_HZ
)(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // crystal clock, sampled as a level
    input  wire logic        xtal_clk,
    // device state
    input  wire logic        unlock_active,
    input  wire logic        idle_mode,
    // register port
    input  wire logic [11:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    // output pin
    output logic             rtc_pin_out,
    output logic             rtc_pin_oe
);

    localparam logic signed [16:0] PRESC_TOP  = 17'(XTAL_CYCLES - 1);
    localparam logic signed [16:0] PRESC_HALF = 17'(XTAL_CYCLES / 2 - 1);
    localparam logic signed [16:0] SYNC_EDGE  = 17'(XTAL_CYCLES - `RTCCA_SYNC_WINDOW);

    if (XTAL_CYCLES < 4 * `RTCCA_SYNC_WINDOW || XTAL_CYCLES > 65536 || XTAL_CYCLES % 2 != 0)
    begin : g_bad_xtal
        $error("XTAL_CYCLES must be even and within 128..65536");
    end

    // control state
    logic [9:0]   cal;
    logic         mod_on;
    logic         stop_in_idle;
    logic         out_sel;
    logic         clk_run;
    logic         wren;
    logic         out_en;
    logic         alm_en;
    logic         chime;
    logic         pulse;
    logic [3:0]   amask;
    logic [7:0]   rpt;
    rtcca_time_s  tm;
    rtcca_date_s  dt;
    rtcca_time_s  atm;
    rtcca_date_s  adt;
    logic signed [16:0] presc;
    logic         xtal_q;
    logic         sec_tick_d;
    logic         half_tick_d;

    // bus decode; the whole interface is dead while idling with stop-in-idle set
    logic         bus_live;
    logic [1:0]   op;
    logic [11:0]  base;
    logic         wr_ctl;
    logic         wr_alm;
    logic         wr_tm;
    logic         wr_dt;
    logic         wr_atm;
    logic         wr_adt;

    assign bus_live = !(stop_in_idle && idle_mode);
    assign op       = bus_addr[3:2];
    assign base     = {bus_addr[11:4], 4'h0};
    assign wr_ctl   = bus_live && bus_wr && base == `RTCCA_OFS_CONTROL;
    assign wr_alm   = bus_live && bus_wr && base == `RTCCA_OFS_ALARM_CTL;
    assign wr_tm    = bus_live && bus_wr && base == `RTCCA_OFS_TIME && wren;
    assign wr_dt    = bus_live && bus_wr && base == `RTCCA_OFS_DATE && wren;
    assign wr_atm   = bus_live && bus_wr && base == `RTCCA_OFS_ALARM_TIME;
    assign wr_adt   = bus_live && bus_wr && base == `RTCCA_OFS_ALARM_DATE;

    function automatic logic [31:0] alias_apply(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [1:0] kind);
        logic [31:0] r;
        r = wd;
        unique case (kind)
            `RTCCA_ALIAS_WRITE:  r = wd;
            `RTCCA_ALIAS_CLEAR:  r = old & ~wd;
            `RTCCA_ALIAS_SET:    r = old | wd;
            `RTCCA_ALIAS_INVERT: r = old ^ wd;
        endcase
        return r;
    endfunction : alias_apply

    function automatic logic [31:0] time_word(input rtcca_time_s t);
        return {2'h0, t.hr10, t.hr01, 1'h0, t.min10, t.min01, 1'h0, t.sec10, t.sec01, 8'h00};
    endfunction : time_word

    function automatic rtcca_time_s word_time(input logic [31:0] w);
        rtcca_time_s t;
        t = {w[29:28], w[27:24], w[22:20], w[19:16], w[14:12], w[11:8]};
        return t;
    endfunction : word_time

    function automatic logic [31:0] date_word(input rtcca_date_s d);
        return {d.yr10, d.yr01, 3'h0, d.mon10, d.mon01, 2'h0, d.day10, d.day01, 5'h00, d.wday};
    endfunction : date_word

    function automatic rtcca_date_s word_date(input logic [31:0] w);
        rtcca_date_s d;
        d = {w[31:28], w[27:24], w[20], w[19:16], w[13:12], w[11:8], w[2:0]};
        return d;
    endfunction : word_date

    // last day of the month in bcd; year%4 from bcd digits, 2000 counts as leap
    function automatic logic [7:0] last_day(input rtcca_date_s d);
        logic leap;
        logic [7:0] m;
        leap = d.yr10[0] ? (d.yr01 == 4'h2 || d.yr01 == 4'h6)
                         : (d.yr01 == 4'h0 || d.yr01 == 4'h4 || d.yr01 == 4'h8);
        m = {3'h0, d.mon10, d.mon01};
        if (m == 8'h02)
            return leap ? 8'h29 : 8'h28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            return 8'h30;
        else
            return 8'h31;
    endfunction : last_day

    // crystal edge and prescaler
    logic xtal_edge;
    logic sec_tick;
    logic half_tick;
    logic min_wrap;
    logic day_wrap;
    logic half_flag;
    logic [7:0] dt_last;

    assign dt_last   = last_day(dt);
    assign xtal_edge = xtal_clk && !xtal_q && mod_on;
    assign sec_tick  = xtal_edge && presc == PRESC_TOP;
    assign half_tick = xtal_edge && presc == PRESC_HALF;
    assign min_wrap  = sec_tick && tm.sec10 == 3'h5 && tm.sec01 == 4'h9;
    assign day_wrap  = min_wrap && tm.min10 == 3'h5 && tm.min01 == 4'h9
                       && tm.hr10 == 2'h2 && tm.hr01 == 4'h3;
    assign half_flag = !presc[16] && presc > PRESC_HALF;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            xtal_q <= 1'b0;
        else
            xtal_q <= xtal_clk;
    end

    // the minute's first second starts offset by the calibration value
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            presc <= 17'sh00000;
        else if (wr_tm)
            presc <= 17'sh00000;
        else if (sec_tick)
            presc <= min_wrap ? 17'(signed'(cal)) : 17'sh00000;
        else if (xtal_edge)
            presc <= presc + 17'sh00001;
    end

    // time of day
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            tm <= '0;
        else if (wr_tm)
            tm <= word_time(alias_apply(time_word(tm), bus_wdata, op) & `RTCCA_TIME_WMASK);
        else if (sec_tick)
        begin
            if (tm.sec01 != 4'h9)
                tm.sec01 <= tm.sec01 + 4'h1;
            else
            begin
                tm.sec01 <= 4'h0;
                tm.sec10 <= (tm.sec10 == 3'h5) ? 3'h0 : tm.sec10 + 3'h1;
            end
            if (min_wrap)
            begin
                if (tm.min01 != 4'h9)
                    tm.min01 <= tm.min01 + 4'h1;
                else
                begin
                    tm.min01 <= 4'h0;
                    tm.min10 <= (tm.min10 == 3'h5) ? 3'h0 : tm.min10 + 3'h1;
                end
                if (tm.min10 == 3'h5 && tm.min01 == 4'h9)
                begin
                    if (tm.hr10 == 2'h2 && tm.hr01 == 4'h3)
                    begin
                        tm.hr10 <= 2'h0;
                        tm.hr01 <= 4'h0;
                    end
                    else if (tm.hr01 == 4'h9)
                    begin
                        tm.hr10 <= tm.hr10 + 2'h1;
                        tm.hr01 <= 4'h0;
                    end
                    else
                        tm.hr01 <= tm.hr01 + 4'h1;
                end
            end
        end
    end

    // calendar; reset gives 2000-01-01 weekday 0 so the counters start legal
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            dt <= '{yr10: 4'h0, yr01: 4'h0, mon10: 1'b0, mon01: 4'h1,
                    day10: 2'h0, day01: 4'h1, wday: 3'h0};
        else if (wr_dt)
            dt <= word_date(alias_apply(date_word(dt), bus_wdata, op) & `RTCCA_DATE_WMASK);
        else if (day_wrap)
        begin
            dt.wday <= (dt.wday == 3'h6) ? 3'h0 : dt.wday + 3'h1;
            if ({dt.day10, dt.day01} == dt_last[5:0])
            begin
                dt.day10 <= 2'h0;
                dt.day01 <= 4'h1;
                if ({dt.mon10, dt.mon01} == 5'h12)
                begin
                    dt.mon10 <= 1'b0;
                    dt.mon01 <= 4'h1;
                    if (dt.yr01 != 4'h9)
                        dt.yr01 <= dt.yr01 + 4'h1;
                    else
                    begin
                        dt.yr01 <= 4'h0;
                        dt.yr10 <= (dt.yr10 == 4'h9) ? 4'h0 : dt.yr10 + 4'h1;
                    end
                end
                else if (dt.mon01 == 4'h9)
                begin
                    dt.mon10 <= 1'b1;
                    dt.mon01 <= 4'h0;
                end
                else
                    dt.mon01 <= dt.mon01 + 4'h1;
            end
            else if (dt.day01 == 4'h9)
            begin
                dt.day10 <= dt.day10 + 2'h1;
                dt.day01 <= 4'h0;
            end
            else
                dt.day01 <= dt.day01 + 4'h1;
        end
    end

    // alarm compare, one cycle after the tick so the new time is seen
    logic match;
    logic alarm_evt;
    logic m_s1;
    logic m_s;
    logic m_m1;
    logic m_m;
    logic m_h;
    logic m_w;
    logic m_d;
    logic m_mo;

    assign m_s1 = tm.sec01 == atm.sec01;
    assign m_s  = m_s1 && tm.sec10 == atm.sec10;
    assign m_m1 = m_s && tm.min01 == atm.min01;
    assign m_m  = m_m1 && tm.min10 == atm.min10;
    assign m_h  = m_m && tm.hr10 == atm.hr10 && tm.hr01 == atm.hr01;
    assign m_w  = m_h && dt.wday == adt.wday;
    assign m_d  = m_h && dt.day10 == adt.day10 && dt.day01 == adt.day01;
    assign m_mo = m_d && dt.mon10 == adt.mon10 && dt.mon01 == adt.mon01;

    always_comb
    begin
        match = 1'b0;
        case (amask)
            RTCCA_AM_HALF_SEC: match = half_tick_d || sec_tick_d;
            RTCCA_AM_SECOND:   match = sec_tick_d;
            RTCCA_AM_TEN_SEC:  match = sec_tick_d && m_s1;
            RTCCA_AM_MINUTE:   match = sec_tick_d && m_s;
            RTCCA_AM_TEN_MIN:  match = sec_tick_d && m_m1;
            RTCCA_AM_HOUR:     match = sec_tick_d && m_m;
            RTCCA_AM_DAY:      match = sec_tick_d && m_h;
            RTCCA_AM_WEEK:     match = sec_tick_d && m_w;
            RTCCA_AM_MONTH:    match = sec_tick_d && m_d;
            RTCCA_AM_YEAR:     match = sec_tick_d && m_mo;
            default:           match = 1'b0;
        endcase
    end

    assign alarm_evt = match && alm_en && mod_on;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sec_tick_d  <= 1'b0;
            half_tick_d <= 1'b0;
        end
        else
        begin
            sec_tick_d  <= sec_tick;
            half_tick_d <= half_tick;
        end
    end

    // alarm control and time/date registers; a software write wins over a same-cycle event
    logic [31:0] alm_word;
    logic [31:0] alm_new;
    logic [31:0] ctl_word;
    logic [31:0] ctl_new;
    logic        rd_sync;
    logic        alm_sync;

    assign rd_sync  = mod_on && !presc[16] && presc >= SYNC_EDGE;
    assign alm_sync = mod_on && !presc[16]
                      && (presc >= SYNC_EDGE || (presc > PRESC_HALF - 17'sh00020
                          && presc <= PRESC_HALF));
    assign alm_word = {16'h0000, alm_en, chime, pulse, alm_sync, amask, rpt};
    assign alm_new  = alias_apply(alm_word, bus_wdata, op);
    assign ctl_word = {6'h00, cal, mod_on, 1'b0, stop_in_idle, 5'h00, out_sel, clk_run, 2'h0,
                       wren, rd_sync, half_flag, out_en};
    assign ctl_new  = alias_apply(ctl_word, bus_wdata, op);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            alm_en <= 1'b0;
            chime  <= 1'b0;
            pulse  <= 1'b0;
            amask  <= 4'h0;
            rpt    <= 8'h00;
        end
        else if (wr_alm)
        begin
            alm_en <= alm_new[`RTCCA_ALM_EN];
            chime  <= alm_new[`RTCCA_ALM_CHIME];
            amask  <= alm_new[`RTCCA_ALM_MASK_MSB:`RTCCA_ALM_MASK_LSB];
            rpt    <= alm_new[`RTCCA_ALM_RPT_MSB:`RTCCA_ALM_RPT_LSB];
            if (!alm_en)
                pulse <= alm_new[`RTCCA_ALM_PIV];
        end
        else if (alarm_evt)
        begin
            pulse <= !pulse;
            if (rpt != 8'h00 || chime)
                rpt <= rpt - 8'h01;
            else
                alm_en <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            atm <= '0;
            adt <= '0;
        end
        else
        begin
            if (wr_atm)
                atm <= word_time(alias_apply(time_word(atm), bus_wdata, op)
                                 & `RTCCA_TIME_WMASK);
            if (wr_adt)
                adt <= word_date(alias_apply(date_word(adt), bus_wdata, op)
                                 & `RTCCA_DATE_WMASK);
        end
    end

    // control register
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cal     <= 10'h000;
            mod_on  <= 1'b0;
            stop_in_idle    <= 1'b0;
            out_sel <= 1'b0;
            wren    <= 1'b0;
            out_en  <= 1'b0;
        end
        else if (wr_ctl)
        begin
            cal     <= ctl_new[`RTCCA_CTL_CAL_MSB:`RTCCA_CTL_CAL_LSB];
            stop_in_idle    <= ctl_new[`RTCCA_CTL_STOP_IN_IDLE];
            out_sel <= ctl_new[`RTCCA_CTL_OUT_SEL];
            out_en  <= ctl_new[`RTCCA_CTL_OUT_EN];
            wren    <= ctl_new[`RTCCA_CTL_WREN] && (wren || unlock_active);
            if (wren)
                mod_on <= ctl_new[`RTCCA_CTL_ON];
        end
    end

    // running status sets on a crystal edge while enabled and clears only when disabled
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            clk_run <= 1'b0;
        else if (!mod_on)
            clk_run <= 1'b0;
        else if (xtal_edge)
            clk_run <= 1'b1;
    end

    // read data one cycle later; aliases read back the base register
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            bus_rdata <= 32'h00000000;
        else if (bus_rd && bus_live)
        begin
            unique case (base)
                `RTCCA_OFS_CONTROL:    bus_rdata <= ctl_word;
                `RTCCA_OFS_ALARM_CTL:  bus_rdata <= alm_word;
                `RTCCA_OFS_TIME:       bus_rdata <= time_word(tm);
                `RTCCA_OFS_DATE:       bus_rdata <= date_word(dt);
                `RTCCA_OFS_ALARM_TIME: bus_rdata <= time_word(atm);
                `RTCCA_OFS_ALARM_DATE: bus_rdata <= date_word(adt);
                default:               bus_rdata <= 32'h00000000;
            endcase
        end
        else
            bus_rdata <= 32'h00000000;
    end

    // pin: seconds clock is the half-second phase, a 1 Hz square wave
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rtc_pin_out <= 1'b0;
            rtc_pin_oe  <= 1'b0;
        end
        else
        begin
            rtc_pin_out <= out_en && (out_sel ? half_flag : pulse);
            rtc_pin_oe  <= out_en && mod_on;
        end
    end

endmodule : rtcca_top

// [hw/rtcca_regs.svh]
// register offsets, field positions, reset values and timing counts of the clock calendar unit
`ifndef RTCCA_REGS_SVH
`define RTCCA_REGS_SVH

`define RTCCA_OFS_CONTROL      12'h200
`define RTCCA_OFS_ALARM_CTL    12'h210
`define RTCCA_OFS_TIME         12'h220
`define RTCCA_OFS_DATE         12'h230
`define RTCCA_OFS_ALARM_TIME   12'h240
`define RTCCA_OFS_ALARM_DATE   12'h250

`define RTCCA_ALIAS_WRITE      2'h0
`define RTCCA_ALIAS_CLEAR      2'h1
`define RTCCA_ALIAS_SET        2'h2
`define RTCCA_ALIAS_INVERT     2'h3

`define RTCCA_CTL_CAL_LSB      16
`define RTCCA_CTL_CAL_MSB      25
`define RTCCA_CTL_ON           15
`define RTCCA_CTL_STOP_IN_IDLE         13
`define RTCCA_CTL_OUT_SEL      7
`define RTCCA_CTL_CLK_RUN      6
`define RTCCA_CTL_WREN         3
`define RTCCA_CTL_RD_SYNC      2
`define RTCCA_CTL_HALF_SEC     1
`define RTCCA_CTL_OUT_EN       0

`define RTCCA_ALM_EN           15
`define RTCCA_ALM_CHIME        14
`define RTCCA_ALM_PIV          13
`define RTCCA_ALM_SYNC         12
`define RTCCA_ALM_MASK_LSB     8
`define RTCCA_ALM_MASK_MSB     11
`define RTCCA_ALM_RPT_LSB      0
`define RTCCA_ALM_RPT_MSB      7

`define RTCCA_TIME_WMASK       32'h3F7F7F00
`define RTCCA_DATE_WMASK       32'hFF1F3F07
`define RTCCA_CONTROL_RESET    32'h00000000
`define RTCCA_ALARM_RESET      32'h00000000

`define RTCCA_XTAL_HZ          32768
`define RTCCA_SYNC_WINDOW      32

`endif

// [hw/rtcca_pkg.sv]
// types shared by the clock calendar unit
package rtcca_pkg;

    typedef struct packed {
        logic [1:0] hr10;
        logic [3:0] hr01;
        logic [2:0] min10;
        logic [3:0] min01;
        logic [2:0] sec10;
        logic [3:0] sec01;
    } rtcca_time_s;

    typedef struct packed {
        logic [3:0] yr10;
        logic [3:0] yr01;
        logic       mon10;
        logic [3:0] mon01;
        logic [1:0] day10;
        logic [3:0] day01;
        logic [2:0] wday;
    } rtcca_date_s;

    typedef enum logic [3:0] {
        RTCCA_AM_HALF_SEC = 4'h0,
        RTCCA_AM_SECOND   = 4'h1,
        RTCCA_AM_TEN_SEC  = 4'h2,
        RTCCA_AM_MINUTE   = 4'h3,
        RTCCA_AM_TEN_MIN  = 4'h4,
        RTCCA_AM_HOUR     = 4'h5,
        RTCCA_AM_DAY      = 4'h6,
        RTCCA_AM_WEEK     = 4'h7,
        RTCCA_AM_MONTH    = 4'h8,
        RTCCA_AM_YEAR     = 4'h9
    } rtcca_amask_e;

endpackage : rtcca_pkg

// [tb/rtcca_xtal_src.sv]
// free-running crystal clock source for the clock calendar unit
`timescale 1ns/10ps
module rtcca_xtal_src #(
    parameter realtime HALF_NS = 100.0
)(
    // crystal output
    output logic xtal_clk
);
    // period scaled down together with the design's count, so a second stays short
    initial
    begin
        xtal_clk = 1'b0;
        #7 forever #(HALF_NS) xtal_clk = ~xtal_clk;
    end
endmodule : rtcca_xtal_src

// [tb/rtcca_chk_props.sv]
// port-level assertions of the clock calendar unit
`timescale 1ns/10ps
module rtcca_chk
    import rtcca_pkg::*;
#(
    parameter int XTAL_CYCLES = 32768
)(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // device state
    input wire logic        xtal_clk,
    input wire logic        unlock_active,
    input wire logic        idle_mode,
    // register port and pin
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic        rtc_pin_out,
    input wire logic        rtc_pin_oe
);
    // idle reads may come back blank, so only reads outside idle are trusted
    wire rdc = bus_rd && !idle_mode && bus_addr[11:4] == 8'h20;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    pin_reset_low_a: assert property ($rose(rst_b) |-> !rtc_pin_out && !rtc_pin_oe)
        else $error("pin active after reset");
    idle_read_blank_a: assert property (bus_rd && idle_mode && bus_addr == 12'h200
        |=> !bus_rdata[13]) else $error("stop bit read in idle");
    pin_off_gated_a: assert property (rdc ##1 !bus_rdata[0]
        |-> !rtc_pin_out && !rtc_pin_oe) else $error("pin active with output off");
    pin_half_sec_a: assert property (rdc ##1 bus_rdata[0] && bus_rdata[7]
        |-> rtc_pin_out == bus_rdata[1]) else $error("pin is not the seconds clock");
    oe_needs_on_a: assert property (rdc ##1 !bus_rdata[15] |-> !rtc_pin_oe)
        else $error("pin enabled with block off");
    alias_reads_a: assert property (rdc && bus_addr[3:0] == 4'h0
        ##1 rdc && bus_addr[3:0] == 4'h4 |=> bus_rdata[31:7] == $past(bus_rdata[31:7]))
        else $error("alias read differs from base");
    clk_stops_off_a: assert property (rdc ##1 !bus_rdata[15] && rdc |=> !bus_rdata[6])
        else $error("clock running with block off");
    time_bcd_a: assert property (bus_rd && !idle_mode && bus_addr == 12'h220 |=>
        bus_rdata[29:28] <= 2'h2 && bus_rdata[27:24] <= 4'h9 && bus_rdata[22:20] <= 3'h5
        && bus_rdata[19:16] <= 4'h9 && bus_rdata[14:12] <= 3'h5 && bus_rdata[11:8] <= 4'h9)
        else $error("time not bcd");
endmodule : rtcca_chk

bind rtcca_top rtcca_chk #(.XTAL_CYCLES(XTAL_CYCLES)) i_rtcca_chk (
    .mclk(mclk), .rst_b(rst_b), .xtal_clk(xtal_clk), .unlock_active(unlock_active),
    .idle_mode(idle_mode), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rtc_pin_out(rtc_pin_out), .rtc_pin_oe(rtc_pin_oe)
);

// [tb/rtcca_top_tb.sv]
// self-checking bench of the clock calendar unit
`timescale 1ns/10ps
module rtcca_top_tb;
    import rtcca_pkg::*;
    // 128 crystal edges of 200 ns make a second of 1024 clocks
    localparam int XC = 128;
    logic        mclk = 1'b0, rst_b = 1'b0, unlock_active = 1'b0, idle_mode = 1'b0;
    logic        bus_wr = 1'b0, bus_rd = 1'b0, xtal_clk, rtc_pin_out, rtc_pin_oe;
    logic [11:0] bus_addr = 12'h000;
    logic [31:0] bus_wdata = 32'h0, bus_rdata, v, d;
    int          failures = 0, checks_done = 0;
    logic [31:0] actl [5] = '{32'h8101, 32'hC100, 32'h8003, 32'h8302, 32'h8A05};
    logic [31:0] aexp [5] = '{32'h0100, 32'hC1FF, 32'h8001, 32'h8301, 32'h8A05};
    int          wcyc [5] = '{2300, 1300, 1300, 2300, 1300};
    always #12.5 mclk = ~mclk;
    rtcca_xtal_src i_rtcca_xtal_src (.xtal_clk(xtal_clk));
    rtcca_top #(.XTAL_CYCLES(XC)) i_rtcca_top (
        .mclk(mclk), .rst_b(rst_b), .xtal_clk(xtal_clk), .unlock_active(unlock_active),
        .idle_mode(idle_mode), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rtc_pin_out(rtc_pin_out), .rtc_pin_oe(rtc_pin_oe)
    );
    function automatic logic [31:0] alias_exp(input logic [31:0] o, w, input int k);
        return k == 1 ? o & ~w : k == 2 ? o | w : o ^ w;
    endfunction : alias_exp
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] w);
        @(posedge mclk);
        bus_addr  <= a;
        bus_wdata <= w;
        bus_wr    <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 r = bus_rdata;
    endtask : rd
    task automatic rc(input logic [11:0] a, input logic [31:0] m, e);
        logic [31:0] r;
        rd(a, r);
        chk(r & m, e);
    endtask : rc
    task automatic finish_test;
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // the sequence needs about 11200 clocks
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        finish_test();
    end
    initial
    begin
        void'($urandom(71));
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        // base then clear alias read back to back
        @(posedge mclk);
        bus_addr <= 12'h200;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_addr <= 12'h204;
        #1 chk(bus_rdata, 32'h0);
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, 32'h0);
        rc(12'h210, '1, 32'h0);
        rc(12'h260, '1, 32'h0);
        wr(12'h208, 32'h8008);
        rc(12'h200, '1, 32'h0);
        v = $urandom & 32'h6FFF;
        wr(12'h210, v);
        repeat (4)
        begin
            for (int k = 1; k < 4; k++)
            begin
                d = $urandom & 32'h6FFF;
                wr({8'h21, 2'(k), 2'b00}, d);
                v = alias_exp(v, d, k);
                rc(12'h210, '1, v);
            end
        end
        @(posedge mclk);
        unlock_active <= 1'b1;
        wr(12'h208, 32'h8);
        unlock_active <= 1'b0;
        rc(12'h200, '1, 32'h8);
        wr(12'h230, 32'h24022806);
        wr(12'h220, 32'h23595900);
        wr(12'h208, 32'h8081);
        repeat (300) @(posedge mclk);
        rc(12'h200, 32'h2, 32'h0);
        repeat (500) @(posedge mclk);
        rc(12'h200, 32'h42, 32'h42);
        repeat (300) @(posedge mclk);
        rc(12'h220, '1, 32'h0);
        rc(12'h230, '1, 32'h24022900);
        // a trim of 16 starts the new minute 16 counts in, so its half flag comes early
        wr(12'h208, 32'h00100000);
        wr(12'h220, 32'h00005900);
        repeat (1468) @(posedge mclk);
        rc(12'h200, 32'h2, 32'h2);
        wr(12'h204, 32'h00100000);
        wr(12'h240, 32'h100);
        // a time write restarts the second, so every alarm case starts in phase
        for (int i = 0; i < 5; i++)
        begin
            wr(12'h220, 32'h0);
            wr(12'h210, actl[i]);
            repeat (wcyc[i]) @(posedge mclk);
            rc(12'h210, 32'hCFFF, aexp[i]);
        end
        // alarm pulse onto the pin; alarm off first so its initial value can be loaded
        wr(12'h204, 32'h80);
        wr(12'h214, 32'h8000);
        @(posedge mclk);
        #1 chk({30'h0, rtc_pin_oe, rtc_pin_out}, 32'h2);
        wr(12'h218, 32'h2000);
        @(posedge mclk);
        #1 chk({30'h0, rtc_pin_oe, rtc_pin_out}, 32'h3);
        wr(12'h208, 32'h2000);
        @(posedge mclk);
        idle_mode <= 1'b1;
        rc(12'h200, '1, 32'h0);
        wr(12'h204, 32'h8000);
        idle_mode <= 1'b0;
        rc(12'h200, 32'h8000, 32'h8000);
        wr(12'h204, 32'h8000);
        // the write task leaves a quiet cycle after the enable is cleared
        wr(12'h220, 32'h12345600);
        wr(12'h204, 32'h8);
        wr(12'h220, 32'h01020300);
        rc(12'h220, '1, 32'h12345600);
        wr(12'h208, 32'h8000);
        rc(12'h200, 32'h8040, 32'h0);
        finish_test();
    end
endmodule : rtcca_top_tb
